// ==== hdl/fsg_frame_sync_top.v ====
// Frame trigger generator with Avalon-MM register slave
//
// The Avalon-MM interface to the registers is this design's own decision.
`include "fsg_frame_sync_consts.vh"

module fsg_frame_sync_top #(
   parameter CNT_W = 24
) (
   input wire ref_clk_i,
   input wire resetn_i,
   input wire [7:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output wire [31:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   input wire port0_tick_i,
   input wire port1_tick_i,
   input wire ref25_tick_i,
   input wire [6:0] gen_pin_i,
   output wire frame_trigger_o
);

   // ---------------------------------------------------------------
   // Generator states
   // ---------------------------------------------------------------
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_RUN = 3'b010;
   localparam [2:0] ST_SHOT = 3'b100;
   localparam [CNT_W-1:0] CNT_STEP = {{(CNT_W-1){1'b0}}, 1'b1};

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   reg ack_q;
   reg [31:0] rdata_q;
   reg [31:0] rdata_d;
   reg [7:0] ctl_q;
   reg [7:0] high_upper_q;
   reg [7:0] high_lower_q;
   reg [7:0] low_upper_q;
   reg [7:0] low_lower_q;
   reg shot_q;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [CNT_W-1:0] cnt_q;
   reg [CNT_W-1:0] cnt_d;
   reg level_q;
   reg level_d;
   reg trigger_q;
   reg trigger_d;
   wire [`FSG_IDX_W-1:0] idx;
   wire wr_en;
   wire [3:0] src;
   wire run;
   wire scheme;
   wire idle_level;
   wire tick;
   wire internal;
   wire external;
   wire pin_level;
   wire [CNT_W-1:0] phase_len;
   wire phase_done;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Length of the phase at the given level, less one
   function [CNT_W-1:0] len_of;
      input lvl;
      input joined;
      input [7:0] hu;
      input [7:0] hl;
      input [7:0] lu;
      input [7:0] ll;
      begin
         if (joined) begin
            len_of = {hl, lu, ll};
         end else if (lvl) begin
            len_of = {{(CNT_W-16){1'b0}}, hu, hl};
         end else begin
            len_of = {{(CNT_W-16){1'b0}}, lu, ll};
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // Avalon-MM handshake
   // ---------------------------------------------------------------
   // Every access is answered one cycle after it appears; the fixed
   // extra cycle lets read data come straight from a flip-flop.
   assign avs_waitrequest_o = ~ack_q;
   assign avs_readdata_o = rdata_q;
   assign idx = avs_address_i[7:`FSG_ADDR_LSB];
   assign wr_en = ack_q & avs_write_i & avs_byteenable_i[0];

   always @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_q <= 1'b0;
         rdata_q <= `FSG_RST_WORD;
      end else begin
         ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
         rdata_q <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   always @* begin
      rdata_d = `FSG_RST_WORD;
      if (avs_read_i & ~ack_q) begin
         case (idx)
            `FSG_IDX_CONTROL: begin
               rdata_d[7:0] = ctl_q;
               rdata_d[`FSG_CTL_SHOT_BIT] = 1'b0;
            end
            `FSG_IDX_HIGH_UPPER: begin
               rdata_d[7:0] = high_upper_q;
            end
            `FSG_IDX_HIGH_LOWER: begin
               rdata_d[7:0] = high_lower_q;
            end
            `FSG_IDX_LOW_UPPER: begin
               rdata_d[7:0] = low_upper_q;
            end
            `FSG_IDX_LOW_LOWER: begin
               rdata_d[7:0] = low_lower_q;
            end
            `FSG_IDX_STATUS: begin
               rdata_d[`FSG_STS_LEVEL_BIT] = trigger_q;
               rdata_d[`FSG_STS_RUN_BIT] = (state_q == ST_RUN);
               rdata_d[`FSG_STS_SHOT_BIT] = (state_q == ST_SHOT);
            end
            default: begin
               rdata_d = `FSG_RST_WORD;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   always @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctl_q <= `FSG_RST_BYTE;
         high_upper_q <= `FSG_RST_BYTE;
         high_lower_q <= `FSG_RST_BYTE;
         low_upper_q <= `FSG_RST_BYTE;
         low_lower_q <= `FSG_RST_BYTE;
         shot_q <= 1'b0;
      end else begin
         shot_q <= 1'b0;
         if (wr_en) begin
            case (idx)
               `FSG_IDX_CONTROL: begin
                  ctl_q <= avs_writedata_i[7:0];
                  ctl_q[`FSG_CTL_SHOT_BIT] <= 1'b0;
                  shot_q <= avs_writedata_i[`FSG_CTL_SHOT_BIT];
               end
               `FSG_IDX_HIGH_UPPER: begin
                  high_upper_q <= avs_writedata_i[7:0];
               end
               `FSG_IDX_HIGH_LOWER: begin
                  high_lower_q <= avs_writedata_i[7:0];
               end
               `FSG_IDX_LOW_UPPER: begin
                  low_upper_q <= avs_writedata_i[7:0];
               end
               `FSG_IDX_LOW_LOWER: begin
                  low_lower_q <= avs_writedata_i[7:0];
               end
               default: begin
                  shot_q <= 1'b0;
               end
            endcase
         end
      end
   end

   assign src = ctl_q[`FSG_CTL_SRC_HI:`FSG_CTL_SRC_LO];
   assign run = ctl_q[`FSG_CTL_RUN_BIT];
   assign scheme = ctl_q[`FSG_CTL_SCHEME_BIT];
   assign idle_level = ctl_q[`FSG_CTL_IDLE_BIT];

   // ---------------------------------------------------------------
   // Source selection
   // ---------------------------------------------------------------
   fsg_source_sel u_src (
      .src_i(src),
      .port0_tick_i(port0_tick_i),
      .port1_tick_i(port1_tick_i),
      .ref25_tick_i(ref25_tick_i),
      .gen_pin_i(gen_pin_i),
      .tick_o(tick),
      .internal_o(internal),
      .external_o(external),
      .pin_level_o(pin_level)
   );

   // ---------------------------------------------------------------
   // Phase generator
   // ---------------------------------------------------------------
   assign phase_len = len_of(level_q, scheme, high_upper_q, high_lower_q, low_upper_q,
      low_lower_q);
   // Count runs 0..len, so a phase spans len+1 time base ticks
   assign phase_done = (cnt_q == phase_len);

   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      level_d = level_q;
      case (state_q)
         ST_IDLE: begin
            level_d = idle_level;
            cnt_d = `FSG_RST_CNT;
            if (run & internal) begin
               state_d = ST_RUN;
            end else if (shot_q & internal) begin
               state_d = ST_SHOT;
               level_d = ~idle_level;
            end
         end
         ST_RUN: begin
            if (!run || !internal) begin
               state_d = ST_IDLE;
               level_d = idle_level;
               cnt_d = `FSG_RST_CNT;
            end else if (tick) begin
               if (phase_done) begin
                  level_d = ~level_q;
                  cnt_d = `FSG_RST_CNT;
               end else begin
                  cnt_d = cnt_q + CNT_STEP;
               end
            end
         end
         ST_SHOT: begin
            // Leaving the internal sources abandons the pulse
            if (!internal) begin
               state_d = ST_IDLE;
               level_d = idle_level;
               cnt_d = `FSG_RST_CNT;
            end else if (tick) begin
               if (phase_done) begin
                  state_d = ST_IDLE;
                  level_d = idle_level;
                  cnt_d = `FSG_RST_CNT;
               end else begin
                  cnt_d = cnt_q + CNT_STEP;
               end
            end
         end
         default: begin
            state_d = ST_IDLE;
            level_d = idle_level;
            cnt_d = `FSG_RST_CNT;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Output select
   // ---------------------------------------------------------------
   always @* begin
      if (external) begin
         trigger_d = pin_level;
      end else if (internal) begin
         trigger_d = level_d;
      end else begin
         // Reserved source codes park the line at its idle level
         trigger_d = idle_level;
      end
   end

   always @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= ST_IDLE;
         cnt_q <= `FSG_RST_CNT;
         level_q <= 1'b0;
         trigger_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         level_q <= level_d;
         trigger_q <= trigger_d;
      end
   end

   assign frame_trigger_o = trigger_q;

endmodule

// ==== hdl/fsg_frame_sync_consts.vh ====
// Register map, field positions, source codes and reset values of the frame trigger generator
`ifndef FSG_FRAME_SYNC_CONSTS_VH
`define FSG_FRAME_SYNC_CONSTS_VH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define FSG_IDX_CONTROL 6'h18
`define FSG_IDX_HIGH_UPPER 6'h19
`define FSG_IDX_HIGH_LOWER 6'h1A
`define FSG_IDX_LOW_UPPER 6'h1B
`define FSG_IDX_LOW_LOWER 6'h1C
`define FSG_IDX_STATUS 6'h30
`define FSG_ADDR_LSB 2
`define FSG_IDX_W 6

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define FSG_CTL_RUN_BIT 0
`define FSG_CTL_SCHEME_BIT 1
`define FSG_CTL_IDLE_BIT 2
`define FSG_CTL_SHOT_BIT 3
`define FSG_CTL_SRC_HI 7
`define FSG_CTL_SRC_LO 4

// ---------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------
`define FSG_STS_LEVEL_BIT 0
`define FSG_STS_RUN_BIT 1
`define FSG_STS_SHOT_BIT 2

// ---------------------------------------------------------------
// Sync source codes
// ---------------------------------------------------------------
`define FSG_SRC_PORT0 4'h0
`define FSG_SRC_PORT1 4'h1
`define FSG_SRC_REF25_TAG 2'h1
`define FSG_SRC_PIN0 4'h8
`define FSG_SRC_PIN4 4'hC
`define FSG_SRC_PIN5 4'hD
`define FSG_SRC_PIN6 4'hE

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define FSG_RST_BYTE 8'h00
`define FSG_RST_WORD 32'h0000_0000
`define FSG_RST_CNT 24'h00_0000

`endif

// ==== hdl/fsg_source_sel.v ====
// Time base and external pin selection for the frame trigger generator
`include "fsg_frame_sync_consts.vh"

module fsg_source_sel (
   input wire [3:0] src_i,
   input wire port0_tick_i,
   input wire port1_tick_i,
   input wire ref25_tick_i,
   input wire [6:0] gen_pin_i,
   output reg tick_o,
   output reg internal_o,
   output reg external_o,
   output reg pin_level_o
);

   // ---------------------------------------------------------------
   // Source decoding
   // ---------------------------------------------------------------
   always @* begin
      tick_o = 1'b0;
      internal_o = 1'b0;
      external_o = 1'b0;
      pin_level_o = 1'b0;
      if (src_i == `FSG_SRC_PORT0) begin
         internal_o = 1'b1;
         tick_o = port0_tick_i;
      end else if (src_i == `FSG_SRC_PORT1) begin
         internal_o = 1'b1;
         tick_o = port1_tick_i;
      end else if (src_i[3:2] == `FSG_SRC_REF25_TAG) begin
         internal_o = 1'b1;
         tick_o = ref25_tick_i;
      end else if (src_i >= `FSG_SRC_PIN0 && src_i <= `FSG_SRC_PIN4) begin
         external_o = 1'b1;
         pin_level_o = gen_pin_i[src_i[2:0]];
      end else if (src_i == `FSG_SRC_PIN5) begin
         external_o = 1'b1;
         pin_level_o = gen_pin_i[5];
      end else if (src_i == `FSG_SRC_PIN6) begin
         // Taken as pin 6 until the printed duplicate is confirmed
         external_o = 1'b1;
         pin_level_o = gen_pin_i[6];
      end
      // Reserved codes leave the trigger idle, no time base at all
   end

endmodule

// ==== tb/fsg_tick_model.sv ====
// Far-side time base model: frame clocks of both ports and the 25MHz reference
module fsg_tick_model #(
   parameter int P0 = 3,
   parameter int P1 = 7,
   parameter int PR = 5
) (
   input wire clk_i,
   input wire resetn_i,
   output logic port0_tick_o,
   output logic port1_tick_o,
   output logic ref25_tick_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int c_q;
   always @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) c_q <= 0;
      else c_q <= c_q + 1;
   end
   // Unequal periods, so a wrong source pick shows in every phase length
   assign port0_tick_o = resetn_i && c_q % P0 == 0;
   assign port1_tick_o = resetn_i && c_q % P1 == 0;
   assign ref25_tick_o = resetn_i && c_q % PR == 0;
endmodule

// ==== tb/fsg_frame_sync_monitor.sv ====
// Bus and trigger checker for the frame trigger generator top
module fsg_frame_sync_monitor #(
   parameter CNT_W = 24
) (
   input wire ref_clk_i,
   input wire resetn_i,
   input wire [7:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   input wire [31:0] avs_readdata_o,
   input wire avs_waitrequest_o,
   input wire [6:0] gen_pin_i,
   input wire frame_trigger_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] ctl_q;
   logic [5:0] idx;
   logic rd_ack, wr_ctl, rsv;
   assign idx = avs_address_i[7:2];
   assign rd_ack = avs_read_i && !avs_waitrequest_o;
   assign wr_ctl = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && idx == 6'h18;
   assign rsv = ctl_q[7:4] == 4'h2 || ctl_q[7:4] == 4'h3 || ctl_q[7:4] == 4'hF;
   // Shadow of the control byte; the one-shot bit never stays set
   always @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) ctl_q <= 8'h00;
      else if (wr_ctl) ctl_q <= avs_writedata_i[7:0] & 8'hF7;
   end
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!resetn_i);
   chk_one_wait: assert property ($rose(avs_read_i || avs_write_i) |->
      avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("late or early answer");
   chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("answer longer than one cycle");
   chk_unmapped_zero: assert property (rd_ack && !(idx inside {[6'h18:6'h1C], 6'h30})
      |-> avs_readdata_o == 32'h0000_0000) else $error("unmapped read not zero");
   chk_upper_zero: assert property (rd_ack |-> avs_readdata_o[31:8] == 24'h00_0000)
      else $error("upper read bits not zero");
   chk_ctl_readback: assert property (rd_ack && idx == 6'h18 |-> avs_readdata_o[7:0] == ctl_q)
      else $error("control readback wrong");
   chk_pin_follow: assert property ($past(ctl_q[7] && ctl_q[6:4] != 3'h7) |->
      frame_trigger_o == $past(gen_pin_i[ctl_q[6:4]])) else $error("pin not passed");
   chk_reserved_idle: assert property ($past(rsv) && $past(rsv, 2) &&
      $past(ctl_q[2], 2) == $past(ctl_q[2]) |-> frame_trigger_o == $past(ctl_q[2]))
      else $error("reserved source not parked at idle");
   chk_shot_pulse: assert property (wr_ctl && avs_writedata_i[3] && !avs_writedata_i[0]
      && !ctl_q[0] && avs_writedata_i[7:4] == ctl_q[7:4] && avs_writedata_i[2] == ctl_q[2]
      && !ctl_q[7] && ctl_q[6:5] != 2'h1 && frame_trigger_o == ctl_q[2]
      |=> ##1 frame_trigger_o != ctl_q[2]) else $error("one-shot did not start");
endmodule

bind fsg_frame_sync_top fsg_frame_sync_monitor #(.CNT_W(CNT_W)) u_monitor (
   .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
   .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .gen_pin_i(gen_pin_i),
   .frame_trigger_o(frame_trigger_o)
);

// ==== tb/fsg_frame_sync_test.sv ====
// Self-checking bench of the frame trigger generator against a register and timing model
module fsg_frame_sync_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] be = 4'h0;
   logic [6:0] pins = 7'h00;
   logic [31:0] rdata;
   logic wreq, trg, t0, t1, t25;
   logic [7:0] mdl [0:63];
   int n_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   fsg_frame_sync_top #(.CNT_W(24)) uut (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .avs_address_i(addr), .avs_read_i(rd),
      .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .port0_tick_i(t0),
      .port1_tick_i(t1), .ref25_tick_i(t25), .gen_pin_i(pins), .frame_trigger_o(trg)
   );
   fsg_tick_model u_ticks (.clk_i(ref_clk_i), .resetn_i(resetn_i), .port0_tick_o(t0),
      .port1_tick_o(t1), .ref25_tick_o(t25));
   initial begin
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   task automatic complete_run();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Ceiling well above the longest phase tests
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] b, output logic [31:0] q);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      be <= b;
      // Only the global cycle ceiling ends a wait for the answer
      do begin
         @(posedge ref_clk_i);
      end while (wreq !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge ref_clk_i);
      if (w && b[0] && a[7:2] >= 6'h18 && a[7:2] <= 6'h1C) begin
         mdl[a[7:2]] = (a[7:2] == 6'h18) ? d[7:0] & 8'hF7 : d[7:0];
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
      logic [31:0] q;
      bus(1'b1, a, d, b, q);
   endtask
   task automatic rreg(input logic [7:0] a);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, 4'hF, q);
      check(q, {24'h00_0000, mdl[a[7:2]]});
   endtask
   // Cycles until the trigger level changes, capped at lim
   task automatic phase(input int lim, output int n);
      logic lv;
      lv = trg;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (trg === lv && n < lim);
   endtask
   initial begin
      int i, j, n, lvl, code;
      logic [31:0] c;
      logic [23:0] h, l;
      logic [6:0] p1;
      int src_t[6] = '{0, 1, 4, 7, 6, 4};
      int per_t[6] = '{3, 7, 5, 5, 5, 5};
      int sch_t[6] = '{0, 0, 0, 1, 0, 1};
      int idl_t[6] = '{0, 1, 0, 1, 0, 0};
      logic [31:0] cnt_t[6] = '{32'h0002_0004, 32'h0001_0000, 32'h0100_0003,
                               32'h5500_0002, 32'h0003_0100, 32'hAA00_0101};
      void'($urandom(16327));
      for (i = 0; i < 64; i++) mdl[i] = 8'h00;
      repeat (2) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      @(posedge ref_clk_i);
      for (i = 24; i <= 28; i++) rreg(8'(i * 4));
      for (j = 0; j < 16; j++) begin
         i = $urandom_range(28, 25);
         wreg(8'(i * 4), $urandom, 4'($urandom));
         rreg(8'(i * 4));
      end
      wreg(8'h14, 32'h0000_00FF, 4'hF);
      rreg(8'h14);
      for (j = 0; j < 6; j++) begin
         c = cnt_t[j];
         for (i = 0; i < 4; i++) wreg(8'(100 + 4 * i), c >> (24 - 8 * i), 4'h1);
         h = sch_t[j] ? c[23:0] : c[31:16];
         l = sch_t[j] ? c[23:0] : c[15:0];
         wreg(8'h60, src_t[j] * 16 + idl_t[j] * 4 + sch_t[j] * 2 + 1, 4'h1);
         // The new idle level reaches the pin one edge after the store
         @(posedge ref_clk_i);
         check(trg, idl_t[j]);
         phase(5000, n);
         for (i = 0; i < 2; i++) begin
            lvl = trg;
            phase(5000, n);
            check(n, ((lvl ? h : l) + 1) * per_t[j]);
         end
         bus(1'b0, 8'hC0, 32'h0000_0000, 4'hF, c);
         check(c >> 1, 32'h0000_0001);
         wreg(8'h60, src_t[j] * 16 + idl_t[j] * 4, 4'h1);
         @(posedge ref_clk_i);
         check(trg, idl_t[j]);
      end
      for (i = 0; i < 4; i++) wreg(8'(100 + 4 * i), i % 2, 4'h1);
      for (j = 0; j < 2; j++) begin
         // Run stays off and each shot is let finish before the next
         wreg(8'h60, 8'h40 + 4 * j, 4'h1);
         wreg(8'h60, 8'h48 + 4 * j, 4'h1);
         phase(20, n);
         check(n, 1);
         phase(50, n);
         check(n >= 6 && n <= 10, 1);
         phase(100, n);
         check(n, 100);
         rreg(8'h60);
      end
      for (code = 8; code < 15; code++) begin
         wreg(8'h60, code * 16, 4'h1);
         p1 = pins;
         repeat (12) begin
            @(posedge ref_clk_i);
            check(trg, p1[code - 8]);
            p1 = pins;
            pins <= 7'($urandom);
         end
      end
      // Reserved sources written on purpose: the output must park at idle
      for (j = 0; j < 3; j++) begin
         code = (j == 2) ? 15 : j + 2;
         wreg(8'h60, code * 16 + 5, 4'h1);
         repeat (3) @(posedge ref_clk_i);
         check(trg, 1);
         rreg(8'h60);
      end
      complete_run();
   end
endmodule
